// ==== rtl/thmon_pkg.sv ====
// Package with register map, field positions, reset values and timing of the thermal monitor.
package thmon_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [3:0] ADDR_THERM_CTRL = 4'h0;
  localparam logic [3:0] ADDR_INT_STS    = 4'h4;
  localparam logic [3:0] ADDR_INT_MSK    = 4'h8;
  localparam logic [3:0] ADDR_SLEEP_KEEP = 4'hc;

  // ****************************************
  // Thermal control and status fields
  // ****************************************
  localparam int BIT_PROT_DIS    = 0;
  localparam int BIT_HOT_MSK     = 1;
  localparam int BIT_SD_MSK      = 2;
  localparam int BIT_HOT_SEL_LO  = 3;
  localparam int BIT_HOT_DET     = 5;
  localparam int BIT_SD_DET      = 6;

  // ****************************************
  // Interrupt status and mask fields
  // ****************************************
  localparam int BIT_IRQ_HOT     = 0;
  localparam int BIT_IRQ_SD_OFF  = 1;
  localparam int IRQ_W           = 2;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RST_THERM_CTRL = 8'h00;
  localparam logic [1:0] RST_INT_MSK    = 2'h0;
  localparam logic       RST_SLEEP_KEEP = 1'b0;

  // ****************************************
  // Debounce timing
  // ****************************************
  localparam int DEB_SAMPLES = 4;
  localparam int DEB_W       = 3;

  // Power state reported by the power state controller.
  typedef enum logic [2:0] {
    THMON_PS_OFF    = 3'b001,
    THMON_PS_ACTIVE = 3'b010,
    THMON_PS_SLEEP  = 3'b100
  } thmon_pstate_t;

endpackage

// ==== rtl/thmon_top.sv ====
// Thermal monitor with hot-die warning, thermal shutdown, recovery and register access.
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module thmon_top (
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  input  wire logic [3:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  input  wire logic       hot_above_i,
  input  wire logic       hot_below_hyst_i,
  input  wire logic       sd_above_i,
  input  wire logic       sd_below_hyst_i,
  input  wire logic [2:0] pstate_i,
  input  wire logic       off_to_active_i,
  output logic      [1:0] hot_level_sel_o,
  output logic            prot_active_o,
  output logic            thermal_reset_o,
  output logic            goto_off_o,
  output logic            power_on_block_o,
  output logic            auto_switch_on_o,
  output logic            rtc_supply_only_o,
  output logic            irq_o
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [3:0] sync1_ff;
  logic [3:0] sync2_ff;
  logic [2:0] ps_sync1_ff;
  logic [2:0] ps_sync2_ff;
  logic       ota_sync1_ff;
  logic       ota_sync2_ff;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      sync1_ff <= 4'h0;
      sync2_ff <= 4'h0;
    end else begin
      sync1_ff <= {sd_below_hyst_i, sd_above_i, hot_below_hyst_i, hot_above_i};
      sync2_ff <= sync1_ff;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ps_sync1_ff  <= thmon_pkg::THMON_PS_OFF;
      ps_sync2_ff  <= thmon_pkg::THMON_PS_OFF;
      ota_sync1_ff <= 1'b0;
      ota_sync2_ff <= 1'b0;
    end else begin
      ps_sync1_ff  <= pstate_i;
      ps_sync2_ff  <= ps_sync1_ff;
      ota_sync1_ff <= off_to_active_i;
      ota_sync2_ff <= ota_sync1_ff;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0]                   ctrl_ff;
  logic [thmon_pkg::IRQ_W-1:0]  sts_ff;
  logic [thmon_pkg::IRQ_W-1:0]  msk_ff;
  logic                         keep_ff;
  logic                         hot_det_ff;
  logic                         sd_det_ff;
  logic                         sd_latch_ff;
  logic                         forced_on_ff;

  // ****************************************
  // Shared decoding
  // ****************************************
  function automatic logic in_off(input logic [2:0] ps);
    in_off = ps == thmon_pkg::THMON_PS_OFF;
  endfunction

  function automatic logic deb_full(input logic [thmon_pkg::DEB_W-1:0] cnt);
    deb_full = cnt == thmon_pkg::DEB_W'(thmon_pkg::DEB_SAMPLES - 1);
  endfunction

  // ****************************************
  // Protection enable
  // ****************************************
  logic prot_en;
  always_comb begin
    prot_en = 1'b0;
    unique case (ps_sync2_ff)
      thmon_pkg::THMON_PS_ACTIVE: prot_en = !ctrl_ff[thmon_pkg::BIT_PROT_DIS] | forced_on_ff;
      thmon_pkg::THMON_PS_SLEEP:  prot_en = keep_ff;
      thmon_pkg::THMON_PS_OFF:    prot_en = sd_latch_ff | forced_on_ff;
      default:                    prot_en = 1'b1;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      forced_on_ff <= 1'b0;
    end else begin
      forced_on_ff <= ota_sync2_ff;
    end
  end

  // ****************************************
  // Detection with debounce and hysteresis
  // ****************************************
  function automatic logic [thmon_pkg::DEB_W-1:0] deb_next(input logic [thmon_pkg::DEB_W-1:0] cnt,
                                                          input logic want, input logic cur);
    if (want == cur) begin
      deb_next = '0;
    end else if (deb_full(cnt)) begin
      deb_next = '0;
    end else begin
      deb_next = cnt + 1'b1;
    end
  endfunction

  logic [thmon_pkg::DEB_W-1:0] hot_cnt_ff;
  logic [thmon_pkg::DEB_W-1:0] sd_cnt_ff;
  logic                        hot_want;
  logic                        sd_want;

  always_comb begin
    hot_want = hot_det_ff ? !sync2_ff[1] : sync2_ff[0];
    sd_want  = sd_det_ff  ? !sync2_ff[3] : sync2_ff[2];
    if (!prot_en) begin
      hot_want = 1'b0;
      sd_want  = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      hot_cnt_ff <= '0;
      sd_cnt_ff  <= '0;
      hot_det_ff <= 1'b0;
      sd_det_ff  <= 1'b0;
    end else begin
      hot_cnt_ff <= deb_next(hot_cnt_ff, hot_want, hot_det_ff);
      sd_cnt_ff  <= deb_next(sd_cnt_ff, sd_want, sd_det_ff);
      if (hot_want != hot_det_ff && deb_full(hot_cnt_ff)) begin
        hot_det_ff <= hot_want;
      end
      if (sd_want != sd_det_ff && deb_full(sd_cnt_ff)) begin
        sd_det_ff <= sd_want;
      end
    end
  end

  // ****************************************
  // Shutdown latch and recovery
  // ****************************************
  logic hot_rise;
  logic sd_rise;
  logic hot_prev_ff;
  logic sd_prev_ff;
  assign hot_rise = hot_det_ff & !hot_prev_ff;
  assign sd_rise  = sd_det_ff & !sd_prev_ff;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      hot_prev_ff <= 1'b0;
      sd_prev_ff  <= 1'b0;
    end else begin
      hot_prev_ff <= hot_det_ff;
      sd_prev_ff  <= sd_det_ff;
    end
  end

  // Cleared only in OFF, so a shutdown that is still switching the device off keeps recovery pending.
  // hold until below hot-die
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      sd_latch_ff <= 1'b0;
    end else if (sd_det_ff) begin
      sd_latch_ff <= 1'b1;
    end else if (!hot_det_ff && in_off(ps_sync2_ff)) begin
      sd_latch_ff <= 1'b0;
    end
  end

  // ****************************************
  // Power controller outputs
  // ****************************************
  logic thermal_reset_ff;
  logic goto_off_ff;
  logic block_ff;
  logic auto_on_ff;
  logic rtc_only_ff;
  logic prot_ff;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      thermal_reset_ff <= 1'b0;
      goto_off_ff      <= 1'b0;
    end else begin
      thermal_reset_ff <= sd_det_ff;
      goto_off_ff      <= sd_rise;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      block_ff <= 1'b0;
    end else begin
      block_ff <= sd_det_ff | (sd_latch_ff & hot_det_ff);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      auto_on_ff <= 1'b0;
    end else begin
      auto_on_ff <= sd_latch_ff & !sd_det_ff & !hot_det_ff & in_off(ps_sync2_ff);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rtc_only_ff <= 1'b1;
    end else begin
      rtc_only_ff <= in_off(ps_sync2_ff);
    end
  end

  // Protection state as reported to the power state controller.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      prot_ff <= 1'b0;
    end else begin
      prot_ff <= prot_en;
    end
  end

  // ****************************************
  // Register bus
  // ****************************************
  logic                        rd_sts;
  logic [thmon_pkg::IRQ_W-1:0] ev;
  assign rd_sts = rd_i && addr_i == thmon_pkg::ADDR_INT_STS;
  assign ev     = {sd_rise, hot_rise & !ctrl_ff[thmon_pkg::BIT_HOT_MSK]};

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ctrl_ff <= thmon_pkg::RST_THERM_CTRL;
      msk_ff  <= thmon_pkg::RST_INT_MSK;
      keep_ff <= thmon_pkg::RST_SLEEP_KEEP;
    end else if (wr_i) begin
      if (addr_i == thmon_pkg::ADDR_THERM_CTRL) ctrl_ff <= {3'h0, wdata_i[4:0]};
      if (addr_i == thmon_pkg::ADDR_INT_MSK)    msk_ff  <= wdata_i[thmon_pkg::IRQ_W-1:0];
      if (addr_i == thmon_pkg::ADDR_SLEEP_KEEP) keep_ff <= wdata_i[0];
    end
  end

  // sticky, set wins over read clear
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      sts_ff <= '0;
    end else begin
      sts_ff <= (rd_sts ? '0 : sts_ff) | ev;
    end
  end

  logic [7:0] rdata_ff;
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rdata_ff <= 8'h00;
    end else if (rd_i) begin
      unique case (addr_i)
        thmon_pkg::ADDR_THERM_CTRL: rdata_ff <= {1'b0, sd_det_ff, hot_det_ff, ctrl_ff[4:0]};
        thmon_pkg::ADDR_INT_STS:    rdata_ff <= {6'h00, sts_ff};
        thmon_pkg::ADDR_INT_MSK:    rdata_ff <= {6'h00, msk_ff};
        thmon_pkg::ADDR_SLEEP_KEEP: rdata_ff <= {7'h00, keep_ff};
        default:                    rdata_ff <= 8'h00;
      endcase
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  logic irq_ff;
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(((rd_sts ? '0 : sts_ff) | ev) & ~msk_ff);
    end
  end

  assign rdata_o           = rdata_ff;
  assign hot_level_sel_o   = ctrl_ff[thmon_pkg::BIT_HOT_SEL_LO +: 2];
  assign prot_active_o     = prot_ff;
  assign thermal_reset_o   = thermal_reset_ff;
  assign goto_off_o        = goto_off_ff;
  assign power_on_block_o  = block_ff;
  assign auto_switch_on_o  = auto_on_ff;
  assign rtc_supply_only_o = rtc_only_ff;
  assign irq_o             = irq_ff;

endmodule

// ==== bench/thmon_monitor.sv ====
// Port checker for the thermal monitor.
`timescale 1ns/1ps
module thmon_monitor (
  input wire logic       core_clk_i,
  input wire logic       rst_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic       sd_above_i,
  input wire logic       sd_below_hyst_i,
  input wire logic [2:0] pstate_i,
  input wire logic       prot_active_o,
  input wire logic       thermal_reset_o,
  input wire logic       goto_off_o,
  input wire logic       power_on_block_o,
  input wire logic       auto_switch_on_o,
  input wire logic       rtc_supply_only_o,
  input wire logic       irq_o
);
  logic [3:0] hi_cnt_ff;
  logic [3:0] lo_cnt_ff;
  logic [3:0] dis_cnt_ff;
  logic       msk_all_ff;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // Saturating run lengths of the raw shutdown inputs and of disabled protection.
  always_ff @(posedge core_clk_i) begin
    hi_cnt_ff  <= (rst_i || !sd_above_i) ? 4'h0 : hi_cnt_ff + {3'h0, hi_cnt_ff != 4'hf};
    lo_cnt_ff  <= (rst_i || !sd_below_hyst_i) ? 4'h0 : lo_cnt_ff + {3'h0, lo_cnt_ff != 4'hf};
    dis_cnt_ff <= (rst_i || prot_active_o) ? 4'h0 : dis_cnt_ff + {3'h0, dis_cnt_ff != 4'hf};
  end
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      msk_all_ff <= 1'b0;
    end else if (wr_i && addr_i == thmon_pkg::ADDR_INT_MSK) begin
      msk_all_ff <= &wdata_i[1:0];
    end
  end
  property p_goto; goto_off_o |=> !goto_off_o; endproperty
  a_goto: assert property (p_goto) else $error("goto pulse too long");
  property p_deb; $rose(thermal_reset_o) |-> $past(hi_cnt_ff, 3) >= 4'h4; endproperty
  a_deb: assert property (p_deb) else $error("shutdown not debounced");
  property p_hyst; $fell(thermal_reset_o) |-> $past(lo_cnt_ff, 3) >= 4'h4 || dis_cnt_ff != 4'h0; endproperty
  a_hyst: assert property (p_hyst) else $error("shutdown cleared early");
  property p_rtc; $stable(pstate_i) [*4] |-> rtc_supply_only_o == (pstate_i == thmon_pkg::THMON_PS_OFF); endproperty
  a_rtc: assert property (p_rtc) else $error("supply state wrong");
  property p_pob; $rose(thermal_reset_o) |-> ##[0:3] power_on_block_o; endproperty
  a_pob: assert property (p_pob) else $error("power-on not blocked");
  property p_auto; $rose(auto_switch_on_o) |-> rtc_supply_only_o; endproperty
  a_auto: assert property (p_auto) else $error("switch-on outside off");
  property p_clr; rd_i && addr_i == thmon_pkg::ADDR_INT_STS |-> ##[1:3] !irq_o; endproperty
  a_clr: assert property (p_clr) else $error("irq not cleared");
  property p_msk; msk_all_ff [*3] |-> !irq_o; endproperty
  a_msk: assert property (p_msk) else $error("masked irq seen");
  property p_rd; !$past(rd_i) |-> rdata_o == 8'h00; endproperty
  a_rd: assert property (p_rd) else $error("stray read data");
  c_sd: cover property ($rose(thermal_reset_o));
  c_auto: cover property ($rose(auto_switch_on_o));
  c_irq: cover property ($rose(irq_o));
endmodule
bind thmon_top thmon_monitor u_mon (
  .core_clk_i        (core_clk_i),
  .rst_i             (rst_i),
  .addr_i            (addr_i),
  .wdata_i           (wdata_i),
  .wr_i              (wr_i),
  .rd_i              (rd_i),
  .rdata_o           (rdata_o),
  .sd_above_i        (sd_above_i),
  .sd_below_hyst_i   (sd_below_hyst_i),
  .pstate_i          (pstate_i),
  .prot_active_o     (prot_active_o),
  .thermal_reset_o   (thermal_reset_o),
  .goto_off_o        (goto_off_o),
  .power_on_block_o  (power_on_block_o),
  .auto_switch_on_o  (auto_switch_on_o),
  .rtc_supply_only_o (rtc_supply_only_o),
  .irq_o             (irq_o)
);

// ==== bench/thmon_psc_model.sv ====
// Power state controller model facing the thermal monitor.
`timescale 1ns/1ps
module thmon_psc_model #(parameter int OTA_CYC = 8) (
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  input  wire logic       goto_off_i,
  input  wire logic       auto_on_i,
  input  wire logic       sleep_req_i,
  output logic      [2:0] pstate_o,
  output logic            ota_o
);
  int cnt;
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pstate_o <= thmon_pkg::THMON_PS_ACTIVE;
      ota_o    <= 1'b0;
      cnt      <= 0;
    end else if (goto_off_i) begin
      pstate_o <= thmon_pkg::THMON_PS_OFF;
    end else if (ota_o) begin
      cnt <= cnt + 1;
      if (cnt == OTA_CYC) begin
        ota_o    <= 1'b0;
        pstate_o <= thmon_pkg::THMON_PS_ACTIVE;
      end
    end else if (pstate_o == thmon_pkg::THMON_PS_OFF) begin
      ota_o <= auto_on_i;
      cnt   <= 0;
    end else begin
      pstate_o <= sleep_req_i ? thmon_pkg::THMON_PS_SLEEP : thmon_pkg::THMON_PS_ACTIVE;
    end
  end
endmodule

// ==== bench/tb_top.sv ====
// Self-checking bench for the thermal monitor.
`timescale 1ns/1ps
module tb_top;
  logic        core_clk_i, rst_i, wr_i, rd_i, rd_d, sleep_req, irq_o;
  logic        hot_above_i, hot_below_hyst_i, sd_above_i, sd_below_hyst_i;
  logic [3:0]  addr_i;
  logic [7:0]  wdata_i, rdata_o;
  logic [1:0]  hot_level_sel_o;
  logic [2:0]  pstate_i;
  logic        off_to_active_i, prot_active_o, thermal_reset_o, goto_off_o;
  logic        power_on_block_o, auto_switch_on_o, rtc_supply_only_o;
  logic [7:0]  exp_q[$];
  logic [31:0] seed, r;
  int          fail_count, n_tests, i;
  thmon_top DUT (
    .core_clk_i        (core_clk_i),
    .rst_i             (rst_i),
    .addr_i            (addr_i),
    .wdata_i           (wdata_i),
    .wr_i              (wr_i),
    .rd_i              (rd_i),
    .rdata_o           (rdata_o),
    .hot_above_i       (hot_above_i),
    .hot_below_hyst_i  (hot_below_hyst_i),
    .sd_above_i        (sd_above_i),
    .sd_below_hyst_i   (sd_below_hyst_i),
    .pstate_i          (pstate_i),
    .off_to_active_i   (off_to_active_i),
    .hot_level_sel_o   (hot_level_sel_o),
    .prot_active_o     (prot_active_o),
    .thermal_reset_o   (thermal_reset_o),
    .goto_off_o        (goto_off_o),
    .power_on_block_o  (power_on_block_o),
    .auto_switch_on_o  (auto_switch_on_o),
    .rtc_supply_only_o (rtc_supply_only_o),
    .irq_o             (irq_o)
  );
  thmon_psc_model #(.OTA_CYC(8)) u_psc (.core_clk_i(core_clk_i), .rst_i(rst_i), .goto_off_i(goto_off_o),
    .auto_on_i(auto_switch_on_o), .sleep_req_i(sleep_req), .pstate_o(pstate_i), .ota_o(off_to_active_i));
  always #2.5 core_clk_i = ~core_clk_i;
  task automatic pause(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH t=%0t saw %h want %h", $time, s, e);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= w;
    rd_i    <= !w;
    if (!w) exp_q.push_back(d);
    pause(1);
    {wr_i, rd_i} <= 2'b00;
    pause(1);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge core_clk_i) begin
    if (rd_d) chk(rdata_o, exp_q.pop_front());
    rd_d <= rd_i;
  end
  initial begin
    #20000;
    fail_count++;
    end_of_test();
  end
  initial begin
    core_clk_i = 1'b0;
    rst_i = 1'b1;
    seed = 32'h5353;
    {addr_i, wdata_i, wr_i, rd_i, sleep_req} = '0;
    {hot_above_i, hot_below_hyst_i, sd_above_i, sd_below_hyst_i} = '0;
    pause(12);
    rst_i <= 1'b0;
    pause(1);
    bus(0, thmon_pkg::ADDR_THERM_CTRL, thmon_pkg::RST_THERM_CTRL);
    bus(0, thmon_pkg::ADDR_INT_MSK, {6'h0, thmon_pkg::RST_INT_MSK});
    bus(0, 4'h2, 8'h00);
    chk({7'h0, prot_active_o}, 8'h01);
    for (i = 0; i < 4; i++) begin
      bus(1, thmon_pkg::ADDR_THERM_CTRL, 8'(i << 3));
      chk({6'h0, hot_level_sel_o}, 8'(i));
    end
    bus(1, thmon_pkg::ADDR_THERM_CTRL, 8'h01);
    pause(4);
    chk({7'h0, prot_active_o}, 8'h00);
    bus(1, thmon_pkg::ADDR_THERM_CTRL, 8'h00);
    sleep_req <= 1'b1;
    for (i = 0; i < 2; i++) begin
      r = (i == 0) ? $random(seed) : ~r;
      bus(1, thmon_pkg::ADDR_SLEEP_KEEP, r[7:0]);
      pause(6);
      chk({7'h0, prot_active_o}, {7'h0, r[0]});
    end
    sleep_req <= 1'b0;
    hot_above_i <= 1'b1;
    pause(3);
    hot_above_i <= 1'b0;
    pause(12);
    chk({7'h0, irq_o}, 8'h00);
    hot_above_i <= 1'b1;
    pause(12);
    chk({7'h0, irq_o}, 8'h01);
    bus(0, thmon_pkg::ADDR_THERM_CTRL, 8'h20);
    bus(0, thmon_pkg::ADDR_INT_STS, 8'h01);
    bus(0, thmon_pkg::ADDR_INT_STS, 8'h00);
    hot_above_i <= 1'b0;
    pause(12);
    bus(0, thmon_pkg::ADDR_THERM_CTRL, 8'h20);
    hot_below_hyst_i <= 1'b1;
    pause(12);
    bus(0, thmon_pkg::ADDR_THERM_CTRL, 8'h00);
    bus(1, thmon_pkg::ADDR_INT_MSK, 8'h03);
    {hot_above_i, hot_below_hyst_i} <= 2'b10;
    pause(12);
    chk({7'h0, irq_o}, 8'h00);
    bus(0, thmon_pkg::ADDR_INT_STS, 8'h01);
    bus(1, thmon_pkg::ADDR_INT_MSK, 8'h00);
    sd_above_i <= 1'b1;
    pause(12);
    chk({6'h0, thermal_reset_o, power_on_block_o}, 8'h03);
    chk({7'h0, rtc_supply_only_o}, 8'h01);
    bus(0, thmon_pkg::ADDR_INT_STS, 8'h02);
    bus(1, thmon_pkg::ADDR_THERM_CTRL, 8'h01);
    {sd_above_i, sd_below_hyst_i} <= 2'b01;
    pause(12);
    chk({5'h0, thermal_reset_o, power_on_block_o, auto_switch_on_o}, 8'h02);
    {hot_above_i, hot_below_hyst_i} <= 2'b01;
    for (i = 0; i < 40 && !off_to_active_i; i++) pause(1);
    pause(5);
    chk({6'h0, off_to_active_i, prot_active_o}, 8'h03);
    pause(20);
    chk({6'h0, rtc_supply_only_o, prot_active_o}, 8'h00);
    end_of_test();
  end
endmodule
